// ===== design/aa_pkg.sv
package aa_pkg;
  // timing base
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int TICK_W = 10;
  localparam int SETTLE_W = 7;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

  // widths and field positions
  localparam int NSLOT = 2;
  localparam int RES_W = 12;
  localparam int HI_W = 4;
  localparam int LO_W = 8;
  localparam int LO_POS = 0;
  localparam int HI_POS = 8;
  localparam int CHAN_W = 3;
  localparam int CUR_W = 2;
  localparam int RATE_W = 4;
  localparam int DLY_W = 8;

  // channel that gets the current source on one-shot conversions, values after reset
  localparam logic [CHAN_W-1:0] CH_CUR = 3'h0;
  localparam logic [RES_W-1:0] RST_RES = 12'h000;

  typedef enum logic [3:0] {
    AA_IDLE = 4'b0001,
    AA_WARM = 4'b0010,
    AA_START = 4'b0100,
    AA_WAIT = 4'b1000
  } aa_state_t;
endpackage : aa_pkg

// ===== design/aa_conv_if.sv
`timescale 1ns/1ps
// synchronised converter answer passed to the controller
interface aa_conv_if;
  logic done;
  logic [11:0] data;
  modport sync_side (output done, output data);
  modport ctrl_side (input done, input data);
endinterface : aa_conv_if

// ===== design/aa_sync.sv
`timescale 1ns/1ps
module aa_sync
  import aa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic adc_done_pin,
  input wire logic [RES_W-1:0] adc_data_pin,
  aa_conv_if.sync_side conv
);
  typedef struct packed {
    logic d1;
    logic [RES_W-1:0] q1;
    logic d2;
    logic [RES_W-1:0] q2;
  } aa_sync_st_t;

  aa_sync_st_t s_reg;
  aa_sync_st_t s_next;

  // two stages; data is held stable by the converter before done rises
  always_comb begin
    s_next = s_reg;
    s_next.d1 = adc_done_pin;
    s_next.q1 = adc_data_pin;
    s_next.d2 = s_reg.d1;
    s_next.q2 = s_reg.q1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign conv.done = s_reg.d2;
  assign conv.data = s_reg.q2;
endmodule : aa_sync

// ===== design/aa_aux_adc_ctrl.sv
`timescale 1ns/1ps
module aa_aux_adc_ctrl
  import aa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic oneshot_mode_enable,
  input wire logic [NSLOT-1:0][CHAN_W-1:0] oneshot_channel_select,
  input wire logic [NSLOT-1:0] oneshot_trigger,
  input wire logic adc_force_on,
  input wire logic [CUR_W-1:0] adc_current_source_cfg,
  input wire logic [NSLOT-1:0] oneshot_done_mask,
  input wire logic [NSLOT-1:0] oneshot_done_clear,
  input wire logic [NSLOT-1:0][CHAN_W-1:0] periodic_channel_select,
  input wire logic [RATE_W-1:0] periodic_rate_counter,
  input wire logic [NSLOT-1:0][HI_W-1:0] limit_high_bits,
  input wire logic [NSLOT-1:0][LO_W-1:0] limit_low_bits,
  input wire logic [NSLOT-1:0] limit_polarity,
  input wire logic [NSLOT-1:0] limit_shutdown_enable,
  input wire logic [NSLOT-1:0] periodic_enable,
  input wire logic [NSLOT-1:0] periodic_limit_mask,
  input wire logic [NSLOT-1:0] periodic_limit_clear,
  input wire logic [DLY_W-1:0] switch_off_delay,
  input wire logic adc_done_pin,
  input wire logic [RES_W-1:0] adc_data_pin,
  output logic adc_power_on,
  output logic adc_start,
  output logic [CHAN_W-1:0] adc_channel,
  output logic [CUR_W-1:0] adc_current_source,
  output logic [NSLOT-1:0][HI_W-1:0] oneshot_result_high,
  output logic [NSLOT-1:0][LO_W-1:0] oneshot_result_low,
  output logic [NSLOT-1:0][HI_W-1:0] periodic_result_high,
  output logic [NSLOT-1:0][LO_W-1:0] periodic_result_low,
  output logic [NSLOT-1:0] oneshot_done_event,
  output logic [NSLOT-1:0] periodic_limit_event,
  output logic irq,
  output logic switch_off_req
);
  typedef struct packed {
    aa_state_t st;
    logic [SETTLE_W-1:0] wcnt;
    logic [TICK_W-1:0] tcnt;
    logic tick;
    logic done_q;
    logic owner;
    logic kind;
    logic start;
    logic [CHAN_W-1:0] chan;
    logic [CUR_W-1:0] cur;
    logic [NSLOT-1:0] os_pend;
    logic [NSLOT-1:0] per_pend;
    logic [NSLOT-1:0] os_flag;
    logic [NSLOT-1:0] per_flag;
    logic [NSLOT-1:0] off;
    logic [NSLOT-1:0][RATE_W-1:0] rcnt;
    logic [NSLOT-1:0][DLY_W-1:0] dcnt;
    logic [NSLOT-1:0][RES_W-1:0] os_res;
    logic [NSLOT-1:0][RES_W-1:0] per_res;
  } aa_ctrl_st_t;

  aa_ctrl_st_t r_reg;
  aa_ctrl_st_t r_next;
  aa_conv_if conv ();

  // sticky flag: a new event wins over a clear in the same cycle
  function automatic logic aa_flag_upd(input logic flag, input logic clr,
                                       input logic set);
    aa_flag_upd = (flag & ~clr) | set;
  endfunction : aa_flag_upd

  // analog answer crosses in through two flip-flops
  aa_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .adc_done_pin(adc_done_pin),
    .adc_data_pin(adc_data_pin),
    .conv(conv)
  );

  // next-state logic for the whole controller
  always_comb begin
    logic done_edge;
    logic [NSLOT-1:0] os_set;
    logic [NSLOT-1:0] per_set;
    logic [RES_W-1:0] thr;
    logic hit;
    logic pick_owner;
    logic pick_kind;
    logic [CHAN_W-1:0] pick_chan;
    done_edge = 1'b0;
    os_set = '0;
    per_set = '0;
    thr = RST_RES;
    hit = 1'b0;
    pick_owner = 1'b0;
    pick_kind = 1'b0;
    pick_chan = '0;
    r_next = r_reg;
    r_next.start = 1'b0;
    r_next.tick = 1'b0;

    // shared time base for rate and switch-off delay
    if (r_reg.tcnt == TICK_LAST) begin
      r_next.tcnt = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.tcnt = r_reg.tcnt + 1'b1;
    end

    done_edge = conv.done & ~r_reg.done_q;
    r_next.done_q = conv.done;

    for (int s = 0; s < NSLOT; s++) begin
      // trigger is a one-cycle request, latched until served
      if (oneshot_trigger[s] & oneshot_mode_enable) begin
        r_next.os_pend[s] = 1'b1;
      end
      // periodic timer: one conversion every rate+1 ticks
      if (!periodic_enable[s]) begin
        r_next.rcnt[s] = '0;
        r_next.per_pend[s] = 1'b0;
      end else if (r_reg.tick) begin
        if (r_reg.rcnt[s] == periodic_rate_counter) begin
          r_next.rcnt[s] = '0;
          r_next.per_pend[s] = 1'b1;
        end else begin
          r_next.rcnt[s] = r_reg.rcnt[s] + 1'b1;
        end
      end
    end

    // fixed priority: one-shots before periodic, slot zero first
    if (r_reg.os_pend[0]) begin
      pick_owner = 1'b0;
      pick_kind = 1'b0;
    end else if (r_reg.os_pend[1]) begin
      pick_owner = 1'b1;
      pick_kind = 1'b0;
    end else if (r_reg.per_pend[0]) begin
      pick_owner = 1'b0;
      pick_kind = 1'b1;
    end else begin
      pick_owner = 1'b1;
      pick_kind = 1'b1;
    end
    pick_chan = pick_kind ? periodic_channel_select[pick_owner]
                          : oneshot_channel_select[pick_owner];

    // conversion sequencer
    unique case (r_reg.st)
      AA_IDLE: begin
        if (|r_reg.os_pend || |r_reg.per_pend) begin
          r_next.owner = pick_owner;
          r_next.kind = pick_kind;
          r_next.chan = pick_chan;
          if (pick_kind) begin
            r_next.per_pend[pick_owner] = 1'b0;
            r_next.cur = '0;
          end else begin
            r_next.os_pend[pick_owner] = 1'b0;
            r_next.cur = (pick_chan == CH_CUR) ? adc_current_source_cfg
                                               : '0;
          end
          r_next.wcnt = '0;
          // forced-on converter skips the settle wait
          r_next.st = adc_force_on ? AA_START : AA_WARM;
        end
      end
      AA_WARM: begin
        if (r_reg.wcnt == SETTLE_LAST) begin
          r_next.st = AA_START;
        end else begin
          r_next.wcnt = r_reg.wcnt + 1'b1;
        end
      end
      AA_START: begin
        r_next.start = 1'b1;
        r_next.st = AA_WAIT;
      end
      AA_WAIT: begin
        if (done_edge) begin
          r_next.st = AA_IDLE;
          r_next.cur = '0;
          if (r_reg.kind) begin
            r_next.per_res[r_reg.owner] = conv.data;
            thr = {limit_high_bits[r_reg.owner],
                   limit_low_bits[r_reg.owner]};
            hit = limit_polarity[r_reg.owner] ? (conv.data < thr)
                                              : (conv.data > thr);
            per_set[r_reg.owner] = hit;
          end else begin
            r_next.os_res[r_reg.owner] = conv.data;
            os_set[r_reg.owner] = 1'b1;
          end
        end
      end
    endcase

    for (int s = 0; s < NSLOT; s++) begin
      r_next.os_flag[s] = aa_flag_upd(r_reg.os_flag[s],
                                      oneshot_done_clear[s],
                                      os_set[s]);
      r_next.per_flag[s] = aa_flag_upd(r_reg.per_flag[s],
                                       periodic_limit_clear[s],
                                       per_set[s]);
      // switch-off delay runs while the event stands
      if (!(r_reg.per_flag[s] & limit_shutdown_enable[s])) begin
        r_next.dcnt[s] = '0;
        r_next.off[s] = 1'b0;
      end else if (r_reg.tick && !r_reg.off[s]) begin
        if (r_reg.dcnt[s] == switch_off_delay) begin
          r_next.off[s] = 1'b1;
        end else begin
          r_next.dcnt[s] = r_reg.dcnt[s] + 1'b1;
        end
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_reg <= '{st: AA_IDLE, default: '0};
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // converter controls
  assign adc_power_on = adc_force_on | (r_reg.st != AA_IDLE);
  assign adc_start = r_reg.start;
  assign adc_channel = r_reg.chan;
  assign adc_current_source = r_reg.cur;

  // result fields and status
  for (genvar g = 0; g < NSLOT; g++) begin : g_res
    assign oneshot_result_high[g] = r_reg.os_res[g][HI_POS +: HI_W];
    assign oneshot_result_low[g] = r_reg.os_res[g][LO_POS +: LO_W];
    assign periodic_result_high[g] = r_reg.per_res[g][HI_POS +: HI_W];
    assign periodic_result_low[g] = r_reg.per_res[g][LO_POS +: LO_W];
  end

  assign oneshot_done_event = r_reg.os_flag;
  assign periodic_limit_event = r_reg.per_flag;
  // masked events onto the interrupt line
  assign irq = |(r_reg.os_flag & ~oneshot_done_mask)
             | |(r_reg.per_flag & ~periodic_limit_mask);
  assign switch_off_req = |r_reg.off;
endmodule : aa_aux_adc_ctrl

// ===== test/aa_aux_adc_ctrl_props.sv
`timescale 1ns/1ps
module aa_props
  import aa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic adc_force_on,
  input wire logic [NSLOT-1:0] oneshot_done_mask,
  input wire logic [NSLOT-1:0] oneshot_done_clear,
  input wire logic [NSLOT-1:0] periodic_limit_mask,
  input wire logic [NSLOT-1:0] periodic_limit_clear,
  input wire logic adc_power_on,
  input wire logic adc_start,
  input wire logic [CHAN_W-1:0] adc_channel,
  input wire logic [CUR_W-1:0] adc_current_source,
  input wire logic [NSLOT-1:0] oneshot_done_event,
  input wire logic [NSLOT-1:0] periodic_limit_event,
  input wire logic irq,
  input wire logic switch_off_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // start strobe lasts one cycle
  AST_START_PULSE: assert property (adc_start |=> !adc_start)
    else $error("start strobe longer than one cycle");
  // interrupt is the or of unmasked flags
  AST_IRQ_MAP: assert property (
    irq == (|(oneshot_done_event & ~oneshot_done_mask)
    || |(periodic_limit_event & ~periodic_limit_mask)))
    else $error("interrupt does not match unmasked flags");
  // one-shot flag 0 and limit flag 1 hold until a clear arrives
  AST_OS_HOLD: assert property (
    oneshot_done_event[0] && !oneshot_done_clear[0] |=> oneshot_done_event[0])
    else $error("one-shot flag dropped without clear");
  AST_PER_HOLD: assert property (
    periodic_limit_event[1] && !periodic_limit_clear[1]
    |=> periodic_limit_event[1])
    else $error("limit flag dropped without clear");
  // current source only on the current-source channel
  AST_CUR_CH: assert property (
    adc_current_source != 2'h0 |-> adc_channel == CH_CUR)
    else $error("current source on wrong channel");
  // forced power and power during a start
  AST_FORCE_PWR: assert property (adc_force_on |-> adc_power_on)
    else $error("forced converter not powered");
  AST_START_PWR: assert property (adc_start |-> adc_power_on)
    else $error("start while converter unpowered");
  // switch-off only follows a set limit flag
  AST_SWOFF_CAUSE: assert property (
    switch_off_req |-> $past(periodic_limit_event) != 2'b00)
    else $error("switch-off request without limit flag");
endmodule : aa_props
bind aa_aux_adc_ctrl aa_props u_props (.clk_sys, .rst, .adc_force_on,
  .oneshot_done_mask, .oneshot_done_clear, .periodic_limit_mask,
  .periodic_limit_clear, .adc_power_on, .adc_start, .adc_channel,
  .adc_current_source, .oneshot_done_event, .periodic_limit_event, .irq,
  .switch_off_req);

// ===== test/aa_aux_adc_ctrl_test.sv
`timescale 1ns/1ps
module aux_adc_conversion_control_test
  import aa_pkg::*;
;
  logic clk_sys, rst, clk_en, oneshot_mode_enable, adc_force_on, irq;
  logic [NSLOT-1:0][CHAN_W-1:0] oneshot_channel_select;
  logic [NSLOT-1:0][CHAN_W-1:0] periodic_channel_select;
  logic [NSLOT-1:0] oneshot_trigger, oneshot_done_mask, oneshot_done_clear;
  logic [NSLOT-1:0] limit_polarity, limit_shutdown_enable, periodic_enable;
  logic [NSLOT-1:0] periodic_limit_mask, periodic_limit_clear;
  logic [NSLOT-1:0] oneshot_done_event, periodic_limit_event;
  logic [NSLOT-1:0][HI_W-1:0] limit_high_bits, oneshot_result_high;
  logic [NSLOT-1:0][HI_W-1:0] periodic_result_high;
  logic [NSLOT-1:0][LO_W-1:0] limit_low_bits, oneshot_result_low;
  logic [NSLOT-1:0][LO_W-1:0] periodic_result_low;
  logic [CUR_W-1:0] adc_current_source_cfg, adc_current_source;
  logic [RATE_W-1:0] periodic_rate_counter;
  logic [DLY_W-1:0] switch_off_delay;
  logic adc_done_pin, adc_power_on, adc_start, switch_off_req;
  logic [RES_W-1:0] adc_data_pin, conv_code;
  logic [CHAN_W-1:0] adc_channel;
  logic [5:0] obs;
  logic [RES_W-1:0] per_code0, per_code1;
  int fails, checks_done;
  int starts = 0;
  time t0;
  assign obs = {adc_start, switch_off_req, periodic_limit_event,
    oneshot_done_event};
  // periodic codes of both slots, high and low fields joined
  assign per_code0 = {periodic_result_high[0], periodic_result_low[0]};
  assign per_code1 = {periodic_result_high[1], periodic_result_low[1]};
  aa_aux_adc_ctrl dut (.clk_sys, .rst, .clk_en, .oneshot_mode_enable,
    .oneshot_channel_select, .oneshot_trigger, .adc_force_on,
    .adc_current_source_cfg, .oneshot_done_mask, .oneshot_done_clear,
    .periodic_channel_select, .periodic_rate_counter, .limit_high_bits,
    .limit_low_bits, .limit_polarity, .limit_shutdown_enable,
    .periodic_enable, .periodic_limit_mask, .periodic_limit_clear,
    .switch_off_delay, .adc_done_pin, .adc_data_pin, .adc_power_on,
    .adc_start, .adc_channel, .adc_current_source, .oneshot_result_high,
    .oneshot_result_low, .periodic_result_high, .periodic_result_low,
    .oneshot_done_event, .periodic_limit_event, .irq, .switch_off_req);
  // clock source
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // counts start strobes
  always @(posedge clk_sys) if (adc_start === 1'b1) starts <= starts + 1;
  // converter stand-in: answers each start, scrambles data when idle
  initial begin
    adc_done_pin = 1'b0;
    adc_data_pin = '0;
    forever begin
      @(negedge clk_sys);
      if (adc_start === 1'b1) begin
        repeat (3) @(negedge clk_sys);
        adc_data_pin = conv_code;
        @(negedge clk_sys);
        adc_done_pin = 1'b1;
        repeat (3) @(negedge clk_sys);
        adc_done_pin = 1'b0;
        adc_data_pin = ~conv_code;
      end
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // bounded wait for one observed bit to go high
  task automatic wait_hi(input int i);
    for (int k = 0; k < 3000 && obs[i] !== 1'b1; k++) @(negedge clk_sys);
    if (obs[i] !== 1'b1) begin
      fails++;
      $display("[ERR] %0t wait ran out on bit %0d", $time, i);
      tally_and_finish();
    end
  endtask : wait_hi
  task automatic oneshot(input int s, input logic [2:0] ch,
                         input logic [11:0] code);
    logic [11:0] cur_exp;
    cur_exp = (ch == CH_CUR) ? 12'(adc_current_source_cfg) : 12'h000;
    conv_code = code;
    oneshot_channel_select[s] = ch;
    oneshot_trigger[s] = 1'b1;
    @(negedge clk_sys);
    oneshot_trigger[s] = 1'b0;
    wait_hi(5);
    check(12'(adc_channel), 12'(ch));
    check(12'(adc_current_source), cur_exp);
    wait_hi(s);
    check({oneshot_result_high[s], oneshot_result_low[s]}, code);
  endtask : oneshot
  task automatic pulse_clear(input logic [3:0] which);
    {periodic_limit_clear, oneshot_done_clear} = which;
    @(negedge clk_sys);
    {periodic_limit_clear, oneshot_done_clear} = 4'h0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse_clear
  initial begin
    {rst, clk_en, oneshot_mode_enable, adc_force_on} = 4'b1100;
    {oneshot_channel_select, periodic_channel_select} = '0;
    {oneshot_trigger, oneshot_done_mask, oneshot_done_clear} = '0;
    {limit_polarity, limit_shutdown_enable, periodic_enable} = '0;
    {periodic_limit_mask, periodic_limit_clear, limit_low_bits} = '0;
    limit_high_bits = {4'h8, 4'h8};
    {adc_current_source_cfg, periodic_rate_counter} = '0;
    {switch_off_delay, fails, checks_done} = '0;
    conv_code = '0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    check({irq, switch_off_req, obs[3:0]}, 12'h000);
    check({oneshot_result_high[0], oneshot_result_low[0]}, '0);
    check(per_code1, RST_RES);
    // trigger while one-shot mode is off is ignored
    oneshot_trigger = 2'b01;
    @(negedge clk_sys);
    oneshot_trigger = 2'b00;
    repeat (300) @(negedge clk_sys);
    check(12'(starts), 12'h000);
    check(12'(adc_power_on), 12'h000);
    // forced power, channel 0 with current source, masked done
    {oneshot_mode_enable, adc_force_on, adc_current_source_cfg} = 4'b1110;
    oneshot_done_mask = 2'b01;
    oneshot(0, 3'h0, 12'habc);
    check(12'(irq), 12'h000);
    oneshot_done_mask = 2'b00;
    @(negedge clk_sys);
    check(12'(irq), 12'h001);
    check(12'(adc_power_on), 12'h001);
    pulse_clear(4'b0001);
    check(12'(oneshot_done_event), 12'h000);
    oneshot(0, 3'h2, 12'h123);
    // slot one, on-demand power
    adc_force_on = 1'b0;
    oneshot(1, 3'h3, 12'h5a1);
    repeat (2) @(negedge clk_sys);
    check(12'(adc_power_on), 12'h000);
    pulse_clear(4'b0011);
    // periodic slot zero above limit, with switch-off
    {conv_code, periodic_channel_select} = {12'h900, 3'h1, 3'h5};
    {limit_shutdown_enable, periodic_enable} = 4'b0101;
    wait_hi(5);
    check(12'(adc_channel), 12'h005);
    wait_hi(2);
    check(per_code0, 12'h900);
    check(12'(irq), 12'h001);
    wait_hi(4);
    periodic_enable = 2'b00;
    repeat (200) @(negedge clk_sys);
    pulse_clear(4'b0100);
    check({switch_off_req, periodic_limit_event}, '0);
    // slot one below limit, rate two ticks
    {limit_polarity, periodic_rate_counter, periodic_enable} = 8'b10000110;
    periodic_limit_mask = 2'b10;
    wait_hi(5);
    t0 = $time;
    repeat (30) @(negedge clk_sys);
    check(per_code1, 12'h900);
    check(12'(periodic_limit_event), 12'h000);
    conv_code = 12'h700;
    wait_hi(5);
    check(12'(($time - t0) / 100), 12'h7d0);
    wait_hi(3);
    check(12'(irq), 12'h000);
    // low clock enable freezes the flag against a clear
    {clk_en, periodic_limit_clear} = 3'b010;
    repeat (3) @(negedge clk_sys);
    check(12'(periodic_limit_event), 12'h002);
    {clk_en, periodic_limit_clear} = 3'b100;
    pulse_clear(4'b1000);
    check(12'(periodic_limit_event), 12'h000);
    tally_and_finish();
  end
endmodule : aux_adc_conversion_control_test
